//--- shared/peak_monitor_pkg.sv
// Constants and carriers shared by the peak monitor and its serializer.
// Assumes an 8-bit register port with 12-bit byte addresses.
package peak_monitor_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFF_MONITOR_CONTROL  = 12'h270;
  localparam logic [11:0] OFF_PERIOD_0         = 12'h271;
  localparam logic [11:0] OFF_PERIOD_1         = 12'h272;
  localparam logic [11:0] OFF_PERIOD_2         = 12'h273;
  localparam logic [11:0] OFF_HOLD_0           = 12'h274;
  localparam logic [11:0] OFF_HOLD_1           = 12'h275;
  localparam logic [11:0] OFF_SIDEBAND_ENA_A   = 12'h279;
  localparam logic [11:0] OFF_SIDEBAND_ENA_B   = 12'h27A;
  localparam logic [11:0] OFF_CTRL_BIT_SEL_A   = 12'h559;
  localparam logic [11:0] OFF_CTRL_BIT_SEL_B   = 12'h55A;
  localparam logic [11:0] OFF_CTRL_BIT_COUNT   = 12'h58F;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          PEAK_ENABLE_BIT      = 1;
  localparam int          SB_ENA_B_BIT         = 1;
  localparam logic [1:0]  SB_ENA_A_MASK        = 2'h3;
  localparam logic [7:0]  REG_RESET            = 8'h00;
  localparam logic [23:0] PERIOD_RESET         = 24'h000000;

  // ----------------------------------------------------------------------
  // Widths and frame layout
  // ----------------------------------------------------------------------
  localparam int          SAMPLE_W             = 14;
  localparam int          PEAK_W               = 13;
  localparam int          PERIOD_W             = 24;
  localparam int          CTRL_W               = 3;
  localparam int          SUBFRAMES            = 5;
  localparam int          SUBFRAME_W           = 5;
  localparam int          FRAME_W              = SUBFRAMES * SUBFRAME_W;
  localparam int          PAYLOAD_W            = SUBFRAMES * (SUBFRAME_W - 1);
  localparam logic        START_BIT            = 1'b1;

  // Sample word toward the link: control bits below the sample LSB
  typedef struct packed {
    logic [SAMPLE_W-1:0] sample;
    logic [CTRL_W-1:0]   ctrl;
  } link_word_s;

endpackage

//--- rtl/sideband_serial_output.sv
// Serializer that sends one peak value as a framed bit stream.
// Assumes start is a one-cycle pulse on the same clock as everything else.
`timescale 1ns/1ps
module sideband_serial_output #(
  parameter int PEAK_W = peak_monitor_pkg::PEAK_W
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              enable,
  input  wire logic              start,
  input  wire logic [PEAK_W-1:0] peak,
  output logic                   ser_bit_r
);

  localparam int FW = peak_monitor_pkg::FRAME_W;
  localparam int PW = peak_monitor_pkg::PAYLOAD_W;
  localparam int SW = peak_monitor_pkg::SUBFRAME_W;

  // ----------------------------------------------------------------------
  // Frame build
  // ----------------------------------------------------------------------
  function automatic logic [FW-1:0] build_frame(input logic [PEAK_W-1:0] p);
    logic [PW-1:0] payload;
    logic [FW-1:0] f;
    payload = {p, {(PW-PEAK_W){1'b0}}};                          // R17
    f = '0;
    for (int i = 0; i < peak_monitor_pkg::SUBFRAMES; i++) begin
      f[FW-1-i*SW]           = peak_monitor_pkg::START_BIT;      // R14
      f[FW-2-i*SW -: SW-1]   = payload[PW-1-i*(SW-1) -: SW-1];   // R17
    end
    return f;
  endfunction

  logic [FW-1:0] shift_r;
  logic [FW-1:0] shift_nxt;
  logic [4:0]    left_r;
  logic [4:0]    left_nxt;
  logic          bit_nxt;

  // A new update restarts the frame; a half frame would be rejected anyway
  assign shift_nxt = start ? build_frame(peak) : {shift_r[FW-2:0], 1'b0};
  assign left_nxt  = start ? 5'(FW) :
                     (left_r != 5'h00) ? left_r - 5'h01 : 5'h00;        // R18
  assign bit_nxt   = enable && (left_nxt != 5'h00) && shift_nxt[FW-1];  // R18

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r   <= '0;
      left_r    <= 5'h00;
      ser_bit_r <= 1'b0;
    end else begin
      shift_r   <= shift_nxt;                                    // R14
      left_r    <= left_nxt;
      ser_bit_r <= bit_nxt;
    end
  end

endmodule

//--- rtl/signal_peak_monitor_sideband.sv
// Peak magnitude monitor with register port and sideband control bit.
// Assumes samples, register port and clock share the decimated clock.
`timescale 1ns/1ps
// Summary of operation
// [R01] Track largest sample magnitude per period
// [R02] Peak 13 bits, period 24-bit sample count
// [R03] Detection runs only with control bit 1
// [R04] Software writes period before enabling detection
// [R05] Enable loads period into per-cycle countdown
// [R06] Keep larger of input and stored magnitude
// [R07] Seed stored magnitude from current sample
// [R08] At count one copy peak to holding
// [R09] Reload timer, seed from next sample
// [R10] Result readable and sent as control bits
// [R11] Sideband needs 0x279[1:0] and 0x27A bit 1
// [R12] Monitor uses most significant control bit
// [R13] Software programs control bit selection registers
// [R14] 25-bit frame, five subframes, MSB first
// [R15] Receiver reassembles frame, checks start bits
// [R16] Control bits appended below sample LSB
// [R17] Start bit then four payload bits
// [R18] Frame per update, bit low otherwise
module signal_peak_monitor_sideband #(
  parameter int SAMPLE_W = peak_monitor_pkg::SAMPLE_W,
  parameter int PEAK_W   = peak_monitor_pkg::PEAK_W,    // R02
  parameter int PERIOD_W = peak_monitor_pkg::PERIOD_W   // R02
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic signed [SAMPLE_W-1:0] sample_in,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [11:0]                reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  output logic [7:0]                      reg_rdata_r,
  output peak_monitor_pkg::link_word_s    link_word_r
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [7:0]          monitor_control_r;
  logic [7:0]          sideband_enable_a_r;
  logic [7:0]          sideband_enable_b_r;
  logic [7:0]          link_control_bit_select_a_r;
  logic [7:0]          link_control_bit_select_b_r;
  logic [7:0]          link_control_bit_count_r;
  logic [PERIOD_W-1:0] monitor_period_value_r;
  logic [PEAK_W-1:0]   peak_hold_r;
  logic [7:0]          rdata_nxt;
  logic [15:0]         hold_ext;

  assign hold_ext = 16'(peak_hold_r);

  always_comb begin
    case (reg_addr)
      peak_monitor_pkg::OFF_MONITOR_CONTROL: rdata_nxt = monitor_control_r;
      peak_monitor_pkg::OFF_PERIOD_0: rdata_nxt = monitor_period_value_r[7:0];
      peak_monitor_pkg::OFF_PERIOD_1: rdata_nxt = monitor_period_value_r[15:8];
      peak_monitor_pkg::OFF_PERIOD_2:
        rdata_nxt = monitor_period_value_r[23:16];
      peak_monitor_pkg::OFF_HOLD_0:         rdata_nxt = hold_ext[7:0];  // R10
      peak_monitor_pkg::OFF_HOLD_1:         rdata_nxt = hold_ext[15:8];
      peak_monitor_pkg::OFF_SIDEBAND_ENA_A: rdata_nxt = sideband_enable_a_r;
      peak_monitor_pkg::OFF_SIDEBAND_ENA_B: rdata_nxt = sideband_enable_b_r;
      peak_monitor_pkg::OFF_CTRL_BIT_SEL_A:
        rdata_nxt = link_control_bit_select_a_r;
      peak_monitor_pkg::OFF_CTRL_BIT_SEL_B:
        rdata_nxt = link_control_bit_select_b_r;
      peak_monitor_pkg::OFF_CTRL_BIT_COUNT:
        rdata_nxt = link_control_bit_count_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      monitor_control_r           <= peak_monitor_pkg::REG_RESET;
      sideband_enable_a_r         <= peak_monitor_pkg::REG_RESET;
      sideband_enable_b_r         <= peak_monitor_pkg::REG_RESET;
      link_control_bit_select_a_r <= peak_monitor_pkg::REG_RESET;
      link_control_bit_select_b_r <= peak_monitor_pkg::REG_RESET;
      link_control_bit_count_r    <= peak_monitor_pkg::REG_RESET;
      monitor_period_value_r      <= peak_monitor_pkg::PERIOD_RESET;
      reg_rdata_r                 <= 8'h00;
    end else begin
      if (reg_rd) begin
        reg_rdata_r <= rdata_nxt;
      end
      if (reg_wr) begin
        case (reg_addr)
          peak_monitor_pkg::OFF_MONITOR_CONTROL:
            monitor_control_r <= reg_wdata;
          peak_monitor_pkg::OFF_PERIOD_0:
            monitor_period_value_r[7:0] <= reg_wdata;
          peak_monitor_pkg::OFF_PERIOD_1:
            monitor_period_value_r[15:8] <= reg_wdata;
          peak_monitor_pkg::OFF_PERIOD_2:
            monitor_period_value_r[23:16] <= reg_wdata;
          peak_monitor_pkg::OFF_SIDEBAND_ENA_A:
            sideband_enable_a_r <= reg_wdata;
          peak_monitor_pkg::OFF_SIDEBAND_ENA_B:
            sideband_enable_b_r <= reg_wdata;
          peak_monitor_pkg::OFF_CTRL_BIT_SEL_A:
            link_control_bit_select_a_r <= reg_wdata;
          peak_monitor_pkg::OFF_CTRL_BIT_SEL_B:
            link_control_bit_select_b_r <= reg_wdata;
          peak_monitor_pkg::OFF_CTRL_BIT_COUNT:
            link_control_bit_count_r <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Peak detector
  // ----------------------------------------------------------------------
  // Full-scale negative has no 13-bit magnitude, so it saturates
  function automatic logic [PEAK_W-1:0] magnitude(
    input logic signed [SAMPLE_W-1:0] s);
    logic [SAMPLE_W-1:0] a;
    a = s[SAMPLE_W-1] ? SAMPLE_W'(-s) : SAMPLE_W'(s);
    return a[SAMPLE_W-1] ? {PEAK_W{1'b1}} : a[PEAK_W-1:0];
  endfunction

  logic                peak_en;
  logic                peak_en_r;
  logic                start_w;
  logic                xfer_w;
  logic                seed_r;
  logic [PEAK_W-1:0]   mag_w;
  logic [PEAK_W-1:0]   peak_now;
  logic [PEAK_W-1:0]   stored_r;
  logic [PEAK_W-1:0]   stored_nxt;
  logic [PERIOD_W-1:0] timer_r;
  logic [PERIOD_W-1:0] timer_nxt;

  assign peak_en  = monitor_control_r[peak_monitor_pkg::PEAK_ENABLE_BIT];
  assign start_w  = peak_en && !peak_en_r;                           // R03
  assign mag_w    = magnitude(sample_in);                            // R01
  assign peak_now = (seed_r || mag_w > stored_r) ? mag_w : stored_r; // R06
  // A period of zero behaves as one: a transfer every sample
  assign xfer_w   = peak_en_r && peak_en &&
                    (timer_r <= PERIOD_W'(1));                       // R08
  assign timer_nxt  = (start_w || xfer_w) ? monitor_period_value_r :
                      timer_r - PERIOD_W'(1);                        // R05
  assign stored_nxt = start_w ? mag_w : peak_now;                    // R07

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      peak_en_r   <= 1'b0;
      seed_r      <= 1'b0;
      stored_r    <= '0;
      timer_r     <= '0;
      peak_hold_r <= '0;
    end else begin
      peak_en_r <= peak_en;
      seed_r    <= xfer_w;                                           // R09
      if (peak_en) begin
        stored_r <= stored_nxt;
        timer_r  <= timer_nxt;                                       // R09
      end
      if (xfer_w) begin
        peak_hold_r <= peak_now;                                     // R08
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sideband control bit and link word
  // ----------------------------------------------------------------------
  logic sb_on;
  logic ser_bit;

  assign sb_on = (sideband_enable_a_r[1:0] == peak_monitor_pkg::SB_ENA_A_MASK)
                 && sideband_enable_b_r[peak_monitor_pkg::SB_ENA_B_BIT]; // R11

  // Holding value is sampled one cycle after its load
  sideband_serial_output #(
    .PEAK_W (PEAK_W)
  ) u_ser (
    .clk       (clk),
    .rst_n     (rst_sync_r),
    .enable    (sb_on),
    .start     (seed_r),
    .peak      (peak_hold_r),
    .ser_bit_r (ser_bit)
  );

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      link_word_r <= '0;
    end else begin
      link_word_r.sample <= sample_in;                               // R16
      link_word_r.ctrl   <= {ser_bit && sb_on, 2'b00};          // R12 R11
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_sync_r);

  a_start_loads: assert property (start_w |=> // R05
    timer_r == $past(monitor_period_value_r) && stored_r == $past(mag_w))
    else $error("enable did not load timer and seed");
  a_seed_current: assert property (start_w ##1 !xfer_w && !seed_r |-> // R07
    stored_r == $past(mag_w))
    else $error("stored magnitude not seeded from sample");
  a_timer_count: assert property ( // R05
    peak_en && peak_en_r && timer_r > PERIOD_W'(1) |=>
    timer_r == $past(timer_r) - PERIOD_W'(1))
    else $error("timer did not count down by one");
  a_hold_xfer: assert property (xfer_w |=> // R08
    peak_hold_r == $past(peak_now) && timer_r == $past(monitor_period_value_r))
    else $error("peak not transferred at count one");
  a_running_max: assert property ( // R06
    peak_en && peak_en_r && !seed_r && !start_w |=>
    stored_r >= $past(stored_r) && stored_r >= $past(mag_w))
    else $error("running peak lost a larger magnitude");
  a_reseed_next: assert property (peak_en && seed_r |=> // R09
    stored_r == $past(mag_w))
    else $error("stored magnitude not reseeded after transfer");
  a_idle_hold: assert property (!peak_en |=> $stable(peak_hold_r)) // R03
    else $error("holding register changed while disabled");
  a_sideband_gate: assert property (!sb_on |=> link_word_r.ctrl == 3'h0) // R11
    else $error("control bit active while sideband disabled");
  a_sample_pass: assert property (1'b1 |=> // R16
    link_word_r.sample == $past(sample_in))
    else $error("sample field does not follow input");
  a_frame_start: assert property (sb_on && seed_r ##1 sb_on |=> // R18
    link_word_r.ctrl == 3'h4)
    else $error("frame did not open with a start bit");

  c_transfer:  cover property (xfer_w ##1 seed_r);
  c_two_xfer:  cover property (xfer_w ##[2:40] xfer_w);
  c_sideband:  cover property (sb_on && link_word_r.ctrl[2]);

endmodule

//--- verif/peak_frame_receiver.sv
// Far-side receiver model: pulls the monitor bit out of each link word.
// Assumes the bit stands one clock and rests low between frames.
`timescale 1ns/1ps
module peak_frame_receiver (
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  input  wire peak_monitor_pkg::link_word_s          word,
  output logic                                       valid,
  output logic [peak_monitor_pkg::PEAK_W-1:0]        peak,
  output logic                                       start_ok,
  output logic                                       pad_ok
);
  logic [24:0] sh;
  logic [4:0]  cnt;
  wire  [19:0] pay = {sh[23:20], sh[18:15], sh[13:10], sh[8:5], sh[3:0]};

  // --------------------------------------------------------------------
  // Reassembly
  // --------------------------------------------------------------------
  assign peak     = pay[19:7];
  assign pad_ok   = (pay[6:0] == 7'h00);
  assign start_ok = sh[24] & sh[19] & sh[14] & sh[9] & sh[4];

  // A frame opens on the first high bit seen while idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt   <= 5'h00;
      sh    <= 25'h0000000;
      valid <= 1'b0;
    end else begin
      valid <= 1'b0;
      if (cnt != 5'h00 || word.ctrl[2]) begin
        sh  <= {sh[23:0], word.ctrl[2]};
        cnt <= (cnt == 5'h18) ? 5'h00 : cnt + 5'h01;
        valid <= (cnt == 5'h18);
      end
    end
  end
endmodule

//--- verif/signal_peak_monitor_sideband_tb.sv
// Self-checking bench for the peak monitor and its sideband bit.
// Assumes the far-side receiver model compiles alongside.
`timescale 1ns/1ps
module signal_peak_monitor_sideband_tb;
  logic                        clk       = 1'b0;
  logic                        rst_n     = 1'b0;
  logic signed [13:0]          sample_in = 14'h0000;
  logic                        reg_wr    = 1'b0;
  logic                        reg_rd    = 1'b0;
  logic [11:0]                 reg_addr  = 12'h000;
  logic [7:0]                  reg_wdata = 8'h00;
  logic [7:0]                  reg_rdata_r;
  peak_monitor_pkg::link_word_s link_word_r;
  logic                        rx_valid, rx_start_ok, rx_pad_ok;
  logic [12:0]                 rx_peak;
  int                          n_fail = 0, comparisons = 0, k, lim;
  logic [7:0]                  exp_rd[$];
  logic [12:0]                 exp_pk[$];
  logic [7:0]                  m_ctl = 8'h00, m_a = 8'h00, m_b = 8'h00;
  logic [23:0]                 m_per = 24'h000000;
  logic [12:0]                 acc, mv, last_hold = 13'h0000;
  logic [13:0]                 sp;
  logic                        m_start = 1'b1, m_first = 1'b1, tk;
  logic                        chk_on = 1'b0;
  logic [11:0] offs[11] = '{12'h270, 12'h271, 12'h272, 12'h273, 12'h274,
    12'h275, 12'h279, 12'h27A, 12'h559, 12'h55A, 12'h58F};
  logic [23:0] pers[5] = '{24'h000028, 24'h000019, 24'h000000, 24'h000007,
    24'h000001};
  logic [7:0]  sba[5] = '{8'h03, 8'h03, 8'h01, 8'h03, 8'h02};
  logic [7:0]  sbb[5] = '{8'h02, 8'h03, 8'h02, 8'h00, 8'h02};

  signal_peak_monitor_sideband u_dut (.clk(clk), .rst_n(rst_n),
    .sample_in(sample_in), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r), .link_word_r(link_word_r));
  peak_frame_receiver u_rx (.clk(clk), .rst_n(rst_n), .word(link_word_r),
    .valid(rx_valid), .peak(rx_peak), .start_ok(rx_start_ok),
    .pad_ok(rx_pad_ok));

  always #12.5 clk = ~clk;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [12:0] mag(input logic signed [13:0] s);
    int v;
    v = (s < 0) ? -int'(s) : int'(s);
    return (v > 8191) ? 13'h1FFF : v[12:0];
  endfunction

  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask

  // One idle cycle between accesses keeps each strobe edge distinct
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    exp_rd.push_back(e);
    @(negedge clk);
    reg_rd = 1'b0;
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Stimulus and reference model
  // --------------------------------------------------------------------
  // Full-scale negative sample now and then to hit magnitude saturation
  always @(negedge clk) begin
    if (chk_on) begin
      sample_in <= ($urandom_range(0, 31) == 0) ? 14'h2000 : 14'($urandom);
    end
  end

  always @(posedge clk) begin
    mv = mag(sample_in);
    if (m_ctl[1]) begin
      if (m_start) begin
        acc     = mv;
        k       = 1;
        m_start = 1'b0;
        lim     = (m_per == 24'h000000) ? 1 : int'(m_per);
        // Enable seeds from its own sample before the timer holds the period
        lim     = lim + int'(m_first);
        m_first = 1'b0;
      end else begin
        acc = (mv > acc) ? mv : acc;
        k++;
      end
      if (k >= lim) begin
        last_hold = acc;
        m_start   = 1'b1;
        if (m_a[1:0] == 2'h3 && m_b[1]) exp_pk.push_back(acc);
      end
    end else begin
      m_start = 1'b1;
      m_first = 1'b1;
    end
    if (reg_wr) begin
      case (reg_addr)
        12'h270: m_ctl = reg_wdata;
        12'h271: m_per[7:0] = reg_wdata;
        12'h272: m_per[15:8] = reg_wdata;
        12'h273: m_per[23:16] = reg_wdata;
        12'h279: m_a = reg_wdata;
        12'h27A: m_b = reg_wdata;
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Output watcher
  // --------------------------------------------------------------------
  initial forever begin
    @(posedge clk);
    tk = reg_rd;
    sp = sample_in;
    #1;
    if (tk) check("read data", (exp_rd.size() > 0) ? 32'(exp_rd.pop_front())
                  : 32'hDEAD, 32'(reg_rdata_r));
    if (chk_on) begin
      check("sample word", 32'(sp), 32'(link_word_r.sample));
      check("spare ctrl", 32'h0, 32'(link_word_r.ctrl[1:0]));
    end
    if (rx_valid) begin
      check("frame peak", (exp_pk.size() > 0) ? 32'(exp_pk.pop_front())
            : 32'hDEAD, 32'(rx_peak));
      check("start bits", 32'h1, 32'(rx_start_ok));
      check("pad bits", 32'h1, 32'(rx_pad_ok));
    end
  end

  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    void'($urandom(32'hED02));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk_on = 1'b1;
    foreach (offs[i]) rd(offs[i], 8'h00);
    rd(12'h300, 8'h00);
    foreach (offs[i]) wr(offs[i], 8'hA5 ^ 8'(i << 2));
    foreach (offs[i]) rd(offs[i], (i == 4 || i == 5) ? 8'h00
                         : 8'hA5 ^ 8'(i << 2));
    wr(12'h300, 8'hFF);
    rd(12'h300, 8'h00);
    $display("test registers done");
    wr(12'h270, 8'h00);
    wr(12'h559, 8'h00);
    wr(12'h55A, 8'h00);
    wr(12'h58F, 8'h01);
    foreach (pers[i]) begin
      wr(12'h271, pers[i][7:0]);
      wr(12'h272, pers[i][15:8]);
      wr(12'h273, pers[i][23:16]);
      wr(12'h279, sba[i]);
      wr(12'h27A, sbb[i]);
      wr(12'h270, 8'h02);
      repeat (3 * ((pers[i] == 0) ? 1 : int'(pers[i])) + 5) @(negedge clk);
      wr(12'h270, 8'h00);
      repeat (30) @(negedge clk);
      rd(12'h274, last_hold[7:0]);
      rd(12'h275, {3'h0, last_hold[12:8]});
      $display("test period %0d done", pers[i]);
    end
    repeat (40) @(negedge clk);
    check("frames left", 32'h0, 32'(exp_pk.size()));
    check("reads left", 32'h0, 32'(exp_rd.size()));
    give_verdict();
  end

  initial begin
    #125000;
    n_fail++;
    $display("FAIL watchdog expected finish seen hang");
    give_verdict();
  end
endmodule
